// *** rtl/gtu_top.sv ***
// Dual module general timer with a classic Wishbone register slave
`timescale 1ns/1ps
module gtu_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [4:0] timer_input_pin_i,
   input wire logic [4:0] direction_input_pin_i,
   input wire logic capture_input_pin_i,
   output logic first_toggle_output_o,
   output logic second_toggle_output_o,
   output logic core2_ovf_o
);
   localparam int NT = gtu_pkg::NT;
   localparam int C1 = gtu_pkg::CORE1;
   localparam int C2 = gtu_pkg::CORE2;
   localparam int A2 = gtu_pkg::AUX2;

   logic [15:0] cnt_q [NT];
   logic [15:0] ctl_q [NT];
   logic [15:0] ldv [NT];
   logic [15:0] capreg_q;
   logic [gtu_pkg::ST_W-1:0] stat_q;
   logic [gtu_pkg::ST_W-1:0] st_clr;
   logic [9:0] pre_q;
   logic [10:0] s1_q;
   logic [10:0] s2_q;
   logic [10:0] sp_q;
   logic [NT-1:0] tin;
   logic [NT-1:0] eud;
   logic [NT-1:0] tinp;
   logic [NT-1:0] eudp;
   logic [NT-1:0] step;
   logic [NT-1:0] down;
   logic [NT-1:0] ov;
   logic [NT-1:0] ld;
   logic tl1_q;
   logic tl2_q;
   logic ovf2_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] rdv;
   logic cap1;
   logic cap2;
   logic trg;
   logic cap_rise;
   logic wen;
   gtu_pkg::gtu_mode_e md1;
   gtu_pkg::gtu_mode_e md2;

   function automatic logic hit_f(input logic [7:0] a, input logic [7:0] r);
      return a[7:2] == r[7:2];
   endfunction

   function automatic logic tick_f(input logic [9:0] p, input logic [3:0] n);
      return (p & ((10'h001 << n) - 10'h001)) == 10'h000;
   endfunction

   function automatic logic [15:0] mrg_f(input logic [15:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   // Only the two first-module aux timers can leave the counting role
   function automatic gtu_pkg::gtu_role_e role_f(input int i, input logic [15:0] c);
      if (i != gtu_pkg::AUX_A && i != gtu_pkg::AUX_B) begin
         return gtu_pkg::ROLE_COUNT;
      end
      return gtu_pkg::gtu_role_e'(c[gtu_pkg::F_ROLE+:2]);
   endfunction

   // ************************************************************
   // Pin synchronisers and prescaler
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 11'h000;
         s2_q <= 11'h000;
         sp_q <= 11'h000;
      end else if (ce_i) begin
         s1_q <= {capture_input_pin_i, direction_input_pin_i, timer_input_pin_i};
         s2_q <= s1_q;
         sp_q <= s2_q;
      end
   end

   assign tin = s2_q[4:0];
   assign eud = s2_q[9:5];
   assign tinp = sp_q[4:0];
   assign eudp = sp_q[9:5];
   assign cap_rise = s2_q[10] & ~sp_q[10];

   // One shared divider; each timer picks its own tap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= gtu_pkg::PRE_RST;
      end else if (ce_i) begin
         pre_q <= pre_q + 10'h001;
      end
   end

   // ************************************************************
   // Timers
   // ************************************************************
   for (genvar i = 0; i < NT; i++) begin : g_tmr
      localparam bit M2 = (i == C2) || (i == A2);
      localparam bit AUX = (i != C1) && (i != C2);
      localparam logic [3:0] SH = M2 ? 4'(gtu_pkg::M2_SH) : 4'(gtu_pkg::M1_SH);
      logic st;
      logic dn;
      logic tk;

      always_comb begin
         tk = tick_f(pre_q, SH + {1'b0, ctl_q[i][gtu_pkg::F_PRE+:3]});
         dn = ctl_q[i][gtu_pkg::F_DN] ^ (ctl_q[i][gtu_pkg::F_XD] & eud[i]);
         case (gtu_pkg::gtu_mode_e'(ctl_q[i][gtu_pkg::F_MODE+:2]))
            gtu_pkg::MODE_TIMER: st = tk;
            gtu_pkg::MODE_GATED: st = tk & (tin[i] == ctl_q[i][gtu_pkg::F_ALT]);
            gtu_pkg::MODE_COUNTER: st = tin[i] & ~tinp[i];
            gtu_pkg::MODE_QUAD: begin
               // A leads B counts up; one step per edge of either signal
               st = (tin[i] ^ tinp[i]) | (eud[i] ^ eudp[i]);
               dn = ~(tin[i] ^ eudp[i]);
            end
            default: st = 1'b0;
         endcase
         if (AUX && ctl_q[i][gtu_pkg::F_TL]) begin
            st = M2 ? ov[C2] : ov[C1];
         end
         if (!ctl_q[i][gtu_pkg::F_RUN] || role_f(i, ctl_q[i]) != gtu_pkg::ROLE_COUNT) begin
            st = 1'b0;
         end
      end

      assign step[i] = st;
      assign down[i] = dn;
      assign ov[i] = st & (dn ? cnt_q[i] == 16'h0000 : cnt_q[i] == 16'hffff);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cnt_q[i] <= gtu_pkg::CNT_RST;
         end else if (ce_i) begin
            if (wen && hit_f(wb_adr_i, gtu_pkg::CNT_A + 8'(4 * i))) begin
               cnt_q[i] <= mrg_f(cnt_q[i], wb_dat_i, wb_sel_i);
            end else if (ld[i]) begin
               cnt_q[i] <= ldv[i];
            end else if (st) begin
               cnt_q[i] <= dn ? cnt_q[i] - 16'h0001 : cnt_q[i] + 16'h0001;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ctl_q[i] <= gtu_pkg::CTL_RST;
         end else if (ce_i && wen && hit_f(wb_adr_i, gtu_pkg::CTL_A + 8'(4 * i))) begin
            ctl_q[i] <= mrg_f(ctl_q[i], wb_dat_i, wb_sel_i);
         end
      end
   end

   // ************************************************************
   // Capture, reload and clear
   // ************************************************************
   // Aux B is looked at last, so it wins if both reload in one cycle
   always_comb begin
      ld = '0;
      cap1 = 1'b0;
      cap2 = 1'b0;
      trg = 1'b0;
      for (int k = 0; k < NT; k++) begin
         ldv[k] = cnt_q[k];
      end
      for (int k = gtu_pkg::AUX_A; k <= gtu_pkg::AUX_B; k += 2) begin
         case (gtu_pkg::gtu_trig_e'(ctl_q[k][gtu_pkg::F_TRIG+:2]))
            gtu_pkg::TRIG_PIN: trg = tin[k] & ~tinp[k];
            gtu_pkg::TRIG_RISE: trg = ov[C1] & ~tl1_q;
            gtu_pkg::TRIG_FALL: trg = ov[C1] & tl1_q;
            default: trg = ov[C1];
         endcase
         if (role_f(k, ctl_q[k]) == gtu_pkg::ROLE_CAPTURE && tin[k] && !tinp[k]) begin
            ld[k] = 1'b1;
            ldv[k] = cnt_q[C1];
            cap1 = 1'b1;
         end
         if (role_f(k, ctl_q[k]) == gtu_pkg::ROLE_RELOAD && trg) begin
            ld[C1] = 1'b1;
            ldv[C1] = cnt_q[k];
         end
      end
      case (gtu_pkg::gtu_csrc_e'(ctl_q[A2][gtu_pkg::F_TRIG+:2]))
         gtu_pkg::CSRC_PIN: cap2 = cap_rise;
         gtu_pkg::CSRC_CNT: cap2 = tin[C1] ^ tinp[C1];
         gtu_pkg::CSRC_DIR: cap2 = eud[C1] ^ eudp[C1];
         default: cap2 = (tin[C1] ^ tinp[C1]) | (eud[C1] ^ eudp[C1]);
      endcase
      if (ctl_q[C2][gtu_pkg::F_RLD] && ov[C2]) begin
         ld[C2] = 1'b1;
         ldv[C2] = capreg_q;
      end
      if (cap2 && ctl_q[A2][gtu_pkg::F_ALT]) begin
         ld[A2] = 1'b1;
         ldv[A2] = 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capreg_q <= gtu_pkg::CAP_RST;
      end else if (ce_i) begin
         if (wen && hit_f(wb_adr_i, gtu_pkg::CAP_A)) begin
            capreg_q <= mrg_f(capreg_q, wb_dat_i, wb_sel_i);
         end else if (cap2) begin
            capreg_q <= cnt_q[A2];
         end
      end
   end

   // ************************************************************
   // Toggle latches and wrap pulse
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl1_q <= 1'b0;
         tl2_q <= 1'b0;
         ovf2_q <= 1'b0;
      end else if (ce_i) begin
         tl1_q <= tl1_q ^ ov[C1];
         tl2_q <= tl2_q ^ ov[C2];
         ovf2_q <= ov[C2];
      end
   end

   assign first_toggle_output_o = tl1_q;
   assign second_toggle_output_o = tl2_q;
   assign core2_ovf_o = ovf2_q;

   // ************************************************************
   // Status flags and Wishbone slave
   // ************************************************************
   assign wen = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
   assign st_clr = (wen && hit_f(wb_adr_i, gtu_pkg::STAT_A) && wb_sel_i[0]) ?
                   wb_dat_i[gtu_pkg::ST_W-1:0] : 7'h00;

   // A new event outranks a clear written in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= gtu_pkg::ST_RST;
      end else if (ce_i) begin
         stat_q <= (stat_q & ~st_clr) | {cap2, cap1, ov};
      end
   end

   always_comb begin
      rdv = 32'h0000_0000;
      for (int k = 0; k < NT; k++) begin
         if (hit_f(wb_adr_i, gtu_pkg::CNT_A + 8'(4 * k))) begin
            rdv = 32'(cnt_q[k]);
         end
         if (hit_f(wb_adr_i, gtu_pkg::CTL_A + 8'(4 * k))) begin
            rdv = 32'(ctl_q[k]);
         end
      end
      if (hit_f(wb_adr_i, gtu_pkg::CAP_A)) begin
         rdv = 32'(capreg_q);
      end
      if (hit_f(wb_adr_i, gtu_pkg::STAT_A)) begin
         rdv = 32'(stat_q);
      end
   end

   // Ack one cycle after the request; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         dat_q <= (wb_cyc_i & wb_stb_i & ~ack_q) ? rdv : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   assign md1 = gtu_pkg::gtu_mode_e'(ctl_q[C1][gtu_pkg::F_MODE+:2]);
   assign md2 = gtu_pkg::gtu_mode_e'(ctl_q[C2][gtu_pkg::F_MODE+:2]);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_wrap_up: assert property (
      ce_i && step[gtu_pkg::AUX_A] && !down[gtu_pkg::AUX_A] && !ld[gtu_pkg::AUX_A] && !wen
      && cnt_q[gtu_pkg::AUX_A] == 16'hffff |=> cnt_q[gtu_pkg::AUX_A] == 16'h0000)
      else $error("aux timer did not wrap to zero");
   a_flag_sticky: assert property (
      ce_i && ov[C2] |=> stat_q[C2] ##1 (stat_q[C2] || $past(wen)))
      else $error("wrap flag not set or lost");
   a_latch_flip: assert property (
      ce_i && ov[C1] |=> tl1_q != $past(tl1_q))
      else $error("toggle latch did not flip on wrap");
   a_m1_step: assert property (
      md1 == gtu_pkg::MODE_TIMER && step[C1] |-> pre_q[1:0] == 2'h0)
      else $error("first module step faster than four clocks");
   a_m2_step: assert property (
      md2 == gtu_pkg::MODE_TIMER && step[C2] |-> pre_q[0] == 1'b0)
      else $error("second module step faster than two clocks");
   a_aux_stop: assert property (
      ce_i && ctl_q[gtu_pkg::AUX_A][gtu_pkg::F_ROLE+:2] != 2'h0 && !wen
      |=> $stable(cnt_q[gtu_pkg::AUX_A]) || $past(ld[gtu_pkg::AUX_A]))
      else $error("aux timer counted in register role");
   a_cap_value: assert property (
      ce_i && ld[gtu_pkg::AUX_A] && !wen
      |=> cnt_q[gtu_pkg::AUX_A] == $past(cnt_q[C1]))
      else $error("aux capture value wrong");
   a_cap2_clear: assert property (
      ce_i && cap2 && ctl_q[A2][gtu_pkg::F_ALT] && !wen
      |=> cnt_q[A2] == 16'h0000 && capreg_q == $past(cnt_q[A2]))
      else $error("capture register or clear wrong");
   // Watches aux B, the timer that the gated scenario drives; latch clocking overrides the gate
   a_gate_hold: assert property (
      ctl_q[gtu_pkg::AUX_B][gtu_pkg::F_MODE+:2] == gtu_pkg::MODE_GATED
      && !ctl_q[gtu_pkg::AUX_B][gtu_pkg::F_TL]
      && tin[gtu_pkg::AUX_B] != ctl_q[gtu_pkg::AUX_B][gtu_pkg::F_ALT]
      |-> !step[gtu_pkg::AUX_B])
      else $error("gated timer counted with gate closed");

   c_pwm_reload: cover property (ce_i && ld[C1] && ov[C1] ##[1:300] ld[C1] && ov[C1]);
   c_cap2: cover property (ce_i && cap2);
   c_quad_down: cover property (md1 == gtu_pkg::MODE_QUAD && step[C1] && down[C1]);
endmodule

// *** rtl/gtu_pkg.sv ***
// Constants, field layout and encodings of the dual module general timer
// What this block does
// - Five 16-bit timers in two modules; chaining only within a module.
// - First module timers select timer, gated, counter or quadrature mode.
// - Timer mode counts system clock divided by a programmable prescaler.
// - Counter mode counts rising edges on the timer input pin.
// - Gated mode counts prescaled ticks only while the gate pin has the chosen level.
// - First module prescaled ticks (timer and gated mode) come at most once every four system clocks.
// - Direction comes from a software bit, optionally flipped by the direction pin.
// - Quadrature mode derives count and direction from signals A and B.
// - First core timer toggle latch flips on wrap, drives pin and aux clocks.
// - An aux timer used as capture or reload register does not count.
// - Capture role latches the first core timer on the aux input pin edge.
// - Reload role copies aux into core on pin edge or chosen latch transition.
// - Two aux timers reloading on opposite latch transitions make free running PWM.
// - Second module has two timers and capture register, two clock resolution.
// - Second module timers count prescaled clock or external input edges.
// - Second module direction set by software or flipped by the direction pin.
// - Second core toggle latch flips on wrap, clocks its aux timer, drives pin.
// - Second core wrap is an output pulse and may reload it from capture register.
// - Capture register grabs second aux timer on capture pin edge, optional clear.
// - That capture may instead trigger on core count or direction input edges.
package gtu_pkg;
   localparam int NT = 5;
   localparam int AUX_A = 0;
   localparam int CORE1 = 1;
   localparam int AUX_B = 2;
   localparam int CORE2 = 3;
   localparam int AUX2 = 4;
   // Register byte offsets; timer i sits at base + 4*i
   localparam logic [7:0] CNT_A = 8'h00;
   localparam logic [7:0] CTL_A = 8'h20;
   localparam logic [7:0] CAP_A = 8'h34;
   localparam logic [7:0] STAT_A = 8'h38;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam int ST_W = 7;
   localparam logic [ST_W-1:0] ST_RST = 7'h00;
   localparam logic [9:0] PRE_RST = 10'h000;
   // Finest step in system clocks, and its log2
   localparam int M1_RES = 4;
   localparam int M2_RES = 2;
   localparam int M1_SH = $clog2(M1_RES);
   localparam int M2_SH = $clog2(M2_RES);
   // Control field and status bit positions
   localparam int F_MODE = 0;
   localparam int F_DN = 2;
   localparam int F_XD = 3;
   localparam int F_RUN = 4;
   localparam int F_PRE = 5;
   localparam int F_ROLE = 8;
   localparam int F_TRIG = 10;
   localparam int F_TL = 12;
   localparam int F_ALT = 13;
   localparam int F_RLD = 14;
   localparam int ST_C1 = 5;
   localparam int ST_C2 = 6;
   typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_QUAD} gtu_mode_e;
   typedef enum logic [1:0] {ROLE_COUNT, ROLE_CAPTURE, ROLE_RELOAD} gtu_role_e;
   typedef enum logic [1:0] {TRIG_PIN, TRIG_RISE, TRIG_FALL, TRIG_ANY} gtu_trig_e;
   typedef enum logic [1:0] {CSRC_PIN, CSRC_CNT, CSRC_DIR, CSRC_BOTH} gtu_csrc_e;
endpackage

// *** verif/gtu_pins.sv ***
// Pin-side model: event pulses, gate and direction levels, quadrature encoder
`timescale 1ns/1ps
module gtu_pins (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] pulse_i,
   input wire logic quad_i,
   input wire logic quad_up_i,
   input wire logic [3:0] hold_i,
   input wire logic [4:0] lvl_i,
   input wire logic [4:0] dlvl_i,
   output logic busy_o,
   output logic [4:0] tin_o,
   output logic [4:0] dir_o,
   output logic cap_o
);
   // ****************************************
   // Event sequencing
   // ****************************************
   logic [4:0] cnt_q;
   logic [5:0] pul_q;
   logic [1:0] ph_q;
   logic qa;
   logic qb;
   // Each event holds for hold_i+1 cycles, then rests hold_i cycles, so the sampler never misses it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 5'h00;
         pul_q <= 6'h00;
         ph_q <= 2'h0;
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
         if (cnt_q == {1'b0, hold_i}) begin
            pul_q <= 6'h00;
         end
      end else if (pulse_i != 6'h00 || quad_i) begin
         cnt_q <= {hold_i, 1'b0};
         pul_q <= pulse_i;
         if (quad_i) begin
            ph_q <= quad_up_i ? ph_q + 2'h1 : ph_q - 2'h1;
         end
      end
   end
   // Phases 00,10,11,01 for (A,B): moving up, A leads B
   assign qa = (ph_q == 2'h1) || (ph_q == 2'h2);
   assign qb = ph_q[1];
   assign busy_o = (cnt_q != 5'h00);
   assign tin_o = lvl_i | pul_q[4:0] | {3'h0, qa, 1'b0};
   assign dir_o = dlvl_i | {3'h0, qb, 1'b0};
   assign cap_o = pul_q[5];
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the dual module general timer
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] RUN = 16'h1 << gtu_pkg::F_RUN;
   localparam logic [15:0] XD = 16'h1 << gtu_pkg::F_XD;
   localparam logic [15:0] TL = 16'h1 << gtu_pkg::F_TL;
   localparam logic [15:0] ALT = 16'h1 << gtu_pkg::F_ALT;
   localparam logic [15:0] RLD = 16'h1 << gtu_pkg::F_RLD;
   localparam logic [15:0] CAPR = 16'h1 << gtu_pkg::F_ROLE;
   localparam logic [15:0] RELR = 16'h2 << gtu_pkg::F_ROLE;
   localparam logic [15:0] TRISE = 16'h1 << gtu_pkg::F_TRIG;
   localparam logic [15:0] TFALL = 16'h2 << gtu_pkg::F_TRIG;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] dato;
   logic ack;
   logic tout1;
   logic tout2;
   logic ovf;
   logic [5:0] pul = 6'h00;
   logic quad = 1'b0;
   logic qup = 1'b0;
   logic [3:0] hold = 4'h3;
   logic [4:0] lvl = 5'h00;
   logic [4:0] dlvl = 5'h00;
   logic busy;
   logic [4:0] tin;
   logic [4:0] din;
   logic cap;
   int bad_count = 0;
   int n_checks = 0;
   gtu_top i_gtu_top (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dato),
      .wb_ack_o(ack), .timer_input_pin_i(tin), .direction_input_pin_i(din),
      .capture_input_pin_i(cap), .first_toggle_output_o(tout1),
      .second_toggle_output_o(tout2), .core2_ovf_o(ovf));
   gtu_pins i_gtu_pins (.clk_i(clk), .rst_i(rst), .pulse_i(pul), .quad_i(quad),
      .quad_up_i(qup), .hold_i(hold), .lvl_i(lvl), .dlvl_i(dlvl), .busy_o(busy),
      .tin_o(tin), .dir_o(din), .cap_o(cap));
   initial begin
      forever #20 clk = ~clk;
   end
   // ****************************************
   // Bus, pin and check tasks
   // ****************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
         output logic [31:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {16'h0000, d};
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("bus ack", 32'h1, {31'h0, ack});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 16'h0000, r);
      chk(nm, e, r);
   endtask
   function automatic logic [7:0] ca(input int i);
      return gtu_pkg::CNT_A + 8'(4 * i);
   endfunction
   function automatic logic [7:0] cc(input int i);
      return gtu_pkg::CTL_A + 8'(4 * i);
   endfunction
   // Hands one event to the pin model and waits out its hold and the input synchroniser
   task automatic ev(input logic [5:0] p, input logic q, input logic up, input logic [3:0] h);
      pul <= p;
      quad <= q;
      qup <= up;
      hold <= h;
      @(posedge clk);
      pul <= 6'h00;
      quad <= 1'b0;
      repeat (2) @(posedge clk);
      for (int t = 0; t < 40 && busy === 1'b1; t++) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask
   task automatic span(input logic l, output int n);
      n = 0;
      for (int t = 0; t < 400 && tout1 !== l; t++) @(posedge clk);
      while (tout1 === l && n < 400) begin
         @(posedge clk);
         n++;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      for (int i = 0; i < gtu_pkg::NT; i++) begin
         rdc("counter", ca(i), 32'h0);
         rdc("control", cc(i), 32'h0);
      end
      rdc("status", gtu_pkg::STAT_A, 32'h0);
      chk("pin outputs", 32'h0, {29'h0, tout1, tout2, ovf});
      wr(8'h3c, 16'hffff);
      rdc("unmapped", 8'h3c, 32'h0);
      wr(ca(gtu_pkg::AUX2), 16'hffff);
      rdc("16-bit counter", ca(gtu_pkg::AUX2), 32'hffff);
   endtask
   // Two reload registers on opposite latch edges: high 4 steps, low 2 steps
   task automatic t_pwm(input int p);
      int n;
      int lo;
      int hi;
      wr(ca(gtu_pkg::AUX_A), 16'hfffc);
      wr(cc(gtu_pkg::AUX_A), RELR | TRISE);
      wr(ca(gtu_pkg::AUX_B), 16'hfffe);
      wr(cc(gtu_pkg::AUX_B), RELR | TFALL);
      wr(ca(gtu_pkg::CORE1), 16'hfff8);
      wr(cc(gtu_pkg::CORE1), RUN | 16'(p << gtu_pkg::F_PRE));
      span(1'b1, n);
      span(1'b0, lo);
      span(1'b1, hi);
      chk("pwm high", 32'(16 << p), 32'(hi));
      chk("pwm low", 32'(8 << p), 32'(lo));
      wr(cc(gtu_pkg::CORE1), 16'h0000);
      rdc("reload holds", ca(gtu_pkg::AUX_A), 32'hfffc);
   endtask
   task automatic t_count;
      wr(ca(gtu_pkg::AUX_A), 16'hffff);
      wr(cc(gtu_pkg::AUX_A), 16'(gtu_pkg::MODE_COUNTER) | XD | RUN);
      repeat (3) ev(6'h01, 1'b0, 1'b0, 4'h3);
      dlvl <= 5'h01;
      repeat (2) ev(6'h01, 1'b0, 1'b0, 4'h8);
      rdc("event count", ca(gtu_pkg::AUX_A), 32'h0);
      rdc("count wrap flag", gtu_pkg::STAT_A, 32'h3);
      wr(cc(gtu_pkg::AUX_A), 16'h0000);
      dlvl <= 5'h00;
   endtask
   task automatic t_quad;
      wr(ca(gtu_pkg::CORE1), 16'h0000);
      wr(ca(gtu_pkg::AUX2), 16'h0abc);
      wr(cc(gtu_pkg::AUX2), 16'(gtu_pkg::CSRC_CNT) << gtu_pkg::F_TRIG);
      wr(cc(gtu_pkg::CORE1), 16'(gtu_pkg::MODE_QUAD) | RUN);
      repeat (5) ev(6'h00, 1'b1, 1'b1, 4'h3);
      repeat (2) ev(6'h00, 1'b1, 1'b0, 4'h3);
      rdc("quad position", ca(gtu_pkg::CORE1), 32'h3);
      rdc("capture on count pin", gtu_pkg::CAP_A, 32'h0abc);
      wr(cc(gtu_pkg::CORE1), 16'h0000);
   endtask
   task automatic t_gate;
      logic [31:0] r;
      wr(ca(gtu_pkg::AUX_B), 16'h0000);
      wr(cc(gtu_pkg::AUX_B), 16'(gtu_pkg::MODE_GATED) | ALT | RUN);
      repeat (40) @(posedge clk);
      rdc("gate closed", ca(gtu_pkg::AUX_B), 32'h0);
      lvl <= 5'h04;
      repeat (40) @(posedge clk);
      lvl <= 5'h00;
      repeat (6) @(posedge clk);
      wb(1'b0, ca(gtu_pkg::AUX_B), 16'h0000, r);
      chk("gate open", 32'h1, {31'h0, (r >= 32'h8) && (r <= 32'hc)});
      // Clock enable low must freeze the running timer; at most one step after it returns
      wr(ca(gtu_pkg::AUX_B), 16'h0000);
      wr(cc(gtu_pkg::AUX_B), RUN);
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      wb(1'b0, ca(gtu_pkg::AUX_B), 16'h0000, r);
      chk("frozen timer", 32'h1, {31'h0, r <= 32'h1});
      wr(cc(gtu_pkg::AUX_B), 16'h0000);
   endtask
   task automatic t_capture;
      wr(gtu_pkg::STAT_A, 16'h007f);
      wr(ca(gtu_pkg::CORE1), 16'h1234);
      wr(cc(gtu_pkg::AUX_A), CAPR);
      ev(6'h01, 1'b0, 1'b0, 4'h3);
      rdc("captured core", ca(gtu_pkg::AUX_A), 32'h1234);
      rdc("capture flag", gtu_pkg::STAT_A, 32'h20);
      wr(gtu_pkg::STAT_A, 16'h0020);
      rdc("flag cleared", gtu_pkg::STAT_A, 32'h0);
      wr(cc(gtu_pkg::AUX_A), 16'h0000);
   endtask
   task automatic t_mod2;
      int n;
      logic l;
      wr(gtu_pkg::CAP_A, 16'hfff0);
      wr(ca(gtu_pkg::AUX2), 16'h0000);
      wr(cc(gtu_pkg::AUX2), TL | ALT | RUN);
      wr(ca(gtu_pkg::CORE2), 16'hffff);
      wr(cc(gtu_pkg::CORE2), RLD | RUN);
      for (int t = 0; t < 100 && ovf !== 1'b1; t++) @(posedge clk);
      l = tout2;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ovf !== 1'b1 && n < 100);
      chk("wrap period", 32'h20, 32'(n));
      chk("second latch", {31'h0, ~l}, {31'h0, tout2});
      wr(cc(gtu_pkg::CORE2), 16'h0000);
      repeat (4) @(posedge clk);
      rdc("aux on latch", ca(gtu_pkg::AUX2), 32'h2);
      rdc("wrap flag", gtu_pkg::STAT_A, 32'h08);
      ev(6'h20, 1'b0, 1'b0, 4'h8);
      rdc("capture reg", gtu_pkg::CAP_A, 32'h2);
      rdc("aux cleared", ca(gtu_pkg::AUX2), 32'h0);
      rdc("capture reg flag", gtu_pkg::STAT_A, 32'h48);
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_pwm(0);
      t_pwm(1);
      t_count();
      t_quad();
      t_gate();
      t_capture();
      t_mod2();
      stop_test();
   end
   // The whole run needs under a thousand cycles; this leaves a wide margin
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
